//--- rtl/swmp_regs.svh
// Opcode fields, function codes and shift amounts of the word multiply and pack group
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef SWMP_REGS_SVH
`define SWMP_REGS_SVH

`define SWMP_OPCODE           7'h7B
`define SWMP_SUBFUNC          3'h0
`define SWMP_OPC_LSB          0
`define SWMP_RD_LSB           7
`define SWMP_SUB_LSB          12
`define SWMP_RS1_LSB          15
`define SWMP_RS2_LSB          20
`define SWMP_FUNC_LSB         25
`define SWMP_F_BT_SH14        7'h3A
`define SWMP_F_BT_SH32        7'h3B
`define SWMP_F_TT             7'h3C
`define SWMP_F_TT_SH14        7'h3D
`define SWMP_F_TT_SH32        7'h3E
`define SWMP_F_PK_LL          7'h3F
`define SWMP_F_PK_LH          7'h40
`define SWMP_F_PK_HH          7'h41
`define SWMP_SHIFT14          14
`define SWMP_SHIFT32          32

`endif

//--- rtl/swmp_pkg.sv
// Types of the word multiply and pack group
package swmp_pkg;
  typedef enum logic [3:0] {
    SWMP_OP_NONE   = 4'h0,
    SWMP_OP_BT_S14 = 4'h1,
    SWMP_OP_BT_S32 = 4'h2,
    SWMP_OP_TT     = 4'h3,
    SWMP_OP_TT_S14 = 4'h4,
    SWMP_OP_TT_S32 = 4'h5,
    SWMP_OP_PK_LL  = 4'h6,
    SWMP_OP_PK_LH  = 4'h7,
    SWMP_OP_PK_HH  = 4'h8
  } swmp_op_t;
endpackage

//--- rtl/swmp_decode.sv
// Instruction decoder for the word multiply and pack group
`timescale 1ns/1ps
`include "swmp_regs.svh"
module swmp_decode (
  input  wire logic [31:0]      instr,
  output swmp_pkg::swmp_op_t    op,
  output logic                  hit,
  output logic [4:0]            rd_idx,
  output logic [4:0]            rs1_idx,
  output logic [4:0]            rs2_idx
);
  logic [6:0] func;
  logic       space;

  assign func    = instr[`SWMP_FUNC_LSB +: 7];
  assign rd_idx  = instr[`SWMP_RD_LSB +: 5];
  assign rs1_idx = instr[`SWMP_RS1_LSB +: 5];
  assign rs2_idx = instr[`SWMP_RS2_LSB +: 5];
  assign space   = (instr[`SWMP_OPC_LSB +: 7] == `SWMP_OPCODE) &&
                   (instr[`SWMP_SUB_LSB +: 3] == `SWMP_SUBFUNC);

  always_comb begin
    op = swmp_pkg::SWMP_OP_NONE;
    if (space) begin
      unique case (func)
        `SWMP_F_BT_SH14: op = swmp_pkg::SWMP_OP_BT_S14;
        `SWMP_F_BT_SH32: op = swmp_pkg::SWMP_OP_BT_S32;
        `SWMP_F_TT:      op = swmp_pkg::SWMP_OP_TT;
        `SWMP_F_TT_SH14: op = swmp_pkg::SWMP_OP_TT_S14;
        `SWMP_F_TT_SH32: op = swmp_pkg::SWMP_OP_TT_S32;
        `SWMP_F_PK_LL:   op = swmp_pkg::SWMP_OP_PK_LL;
        `SWMP_F_PK_LH:   op = swmp_pkg::SWMP_OP_PK_LH;
        `SWMP_F_PK_HH:   op = swmp_pkg::SWMP_OP_PK_HH;
        // Other functions belong to neighbouring units
        default:         op = swmp_pkg::SWMP_OP_NONE;
      endcase
    end
  end

  assign hit = (op != swmp_pkg::SWMP_OP_NONE);
endmodule

//--- rtl/swmp_mul32.sv
// Signed 32 by 32 multiplier giving a 64-bit product
`timescale 1ns/1ps
module swmp_mul32 (
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic [63:0]      p
);
  logic signed [63:0] a_ext;
  logic signed [63:0] b_ext;

  // Sign extension before the product keeps the upper half correct
  assign a_ext = {{32{a[31]}}, a};
  assign b_ext = {{32{b[31]}}, b};
  assign p     = a_ext * b_ext;
endmodule

//--- rtl/swmp_top.sv
// Word multiply and pack execution datapath with registered result
`timescale 1ns/1ps
`include "swmp_regs.svh"
module swmp_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr,
  input  wire logic [63:0] rs1_val,
  input  wire logic [63:0] rs2_val,
  output logic             hit,
  output logic [4:0]       rs1_idx,
  output logic [4:0]       rs2_idx,
  output logic             wb_valid,
  output logic [4:0]       wb_rd,
  output logic [63:0]      wb_data,
  output logic             exc_raise
);
  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  swmp_pkg::swmp_op_t op;
  logic [4:0]         rd_idx;

  swmp_decode u_dec (
    .instr   (instr),
    .op      (op),
    .hit     (hit),
    .rd_idx  (rd_idx),
    .rs1_idx (rs1_idx),
    .rs2_idx (rs2_idx)
  );

  // ----------------------------------------------------------------------------
  // Operand selection and multiply
  // ----------------------------------------------------------------------------
  logic [31:0] mul_a;
  logic [31:0] mul_b;
  logic [63:0] prod;

  always_comb begin
    mul_a = rs1_val[63:32];
    mul_b = rs2_val[63:32];
    unique case (op)
      swmp_pkg::SWMP_OP_BT_S14: begin
        mul_a = rs1_val[31:0];
        mul_b = rs2_val[63:32];
      end
      swmp_pkg::SWMP_OP_BT_S32: begin
        // Low word by low word, although the name hints at a high word
        mul_a = rs1_val[31:0];
        mul_b = rs2_val[31:0];
      end
      default: begin
        mul_a = rs1_val[63:32];
        mul_b = rs2_val[63:32];
      end
    endcase
  end

  swmp_mul32 u_mul (
    .a (mul_a),
    .b (mul_b),
    .p (prod)
  );

  // ----------------------------------------------------------------------------
  // Result select
  // ----------------------------------------------------------------------------
  logic [63:0] res;
  logic [63:0] sh14;
  logic [63:0] sh32;

  assign sh14 = $signed(prod) >>> `SWMP_SHIFT14;
  assign sh32 = $signed(prod) >>> `SWMP_SHIFT32;

  always_comb begin
    res = 64'h0;
    unique case (op)
      swmp_pkg::SWMP_OP_BT_S14: res = sh14;
      swmp_pkg::SWMP_OP_BT_S32: res = sh32;
      swmp_pkg::SWMP_OP_TT:     res = prod;
      swmp_pkg::SWMP_OP_TT_S14: res = sh14;
      swmp_pkg::SWMP_OP_TT_S32: res = sh32;
      swmp_pkg::SWMP_OP_PK_LL:  res = {rs1_val[31:0], rs2_val[31:0]};
      swmp_pkg::SWMP_OP_PK_LH:  res = {rs1_val[31:0], rs2_val[63:32]};
      swmp_pkg::SWMP_OP_PK_HH:  res = {rs1_val[63:32], rs2_val[63:32]};
      default:                  res = 64'h0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Writeback register
  // ----------------------------------------------------------------------------
  logic        wb_valid_q;
  logic        wb_valid_d;
  logic [4:0]  wb_rd_q;
  logic [4:0]  wb_rd_d;
  logic [63:0] wb_data_q;
  logic [63:0] wb_data_d;

  always_comb begin
    wb_valid_d = issue_valid && hit;
    wb_rd_d    = wb_rd_q;
    wb_data_d  = wb_data_q;
    // Only the destination is written; no flags leave this unit
    if (issue_valid && hit) begin
      wb_rd_d   = rd_idx;
      wb_data_d = res;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_valid_q <= 1'b0;
      wb_rd_q    <= 5'h00;
      wb_data_q  <= 64'h0;
    end else begin
      wb_valid_q <= wb_valid_d;
      wb_rd_q    <= wb_rd_d;
      wb_data_q  <= wb_data_d;
    end
  end

  assign wb_valid  = wb_valid_q;
  assign wb_rd     = wb_rd_q;
  assign wb_data   = wb_data_q;
  assign exc_raise = 1'b0;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence issue_s(logic [6:0] f);
    issue_valid && instr[6:0] == 7'h7B && instr[14:12] == 3'h0 && instr[31:25] == f;
  endsequence

  property mul_p(logic [6:0] f, logic [63:0] exp_v);
    @(posedge clk) disable iff (sys_rst)
      issue_s(f) |=> wb_valid && wb_data == $past(exp_v);
  endproperty

  logic [63:0] e_bt14;
  logic [63:0] e_bt32;
  logic [63:0] e_tt;
  assign e_bt14 = ($signed({{32{rs1_val[31]}}, rs1_val[31:0]}) *
                   $signed({{32{rs2_val[63]}}, rs2_val[63:32]})) >>> 14;
  assign e_bt32 = ($signed({{32{rs1_val[31]}}, rs1_val[31:0]}) *
                   $signed({{32{rs2_val[31]}}, rs2_val[31:0]})) >>> 32;
  assign e_tt   = $signed({{32{rs1_val[63]}}, rs1_val[63:32]}) *
                  $signed({{32{rs2_val[63]}}, rs2_val[63:32]});

  bt_shift14_a: assert property (mul_p(7'h3A, e_bt14)) else $error("bt shift14 wrong");
  bt_shift32_a: assert property (mul_p(7'h3B, e_bt32)) else $error("bt shift32 wrong");
  tt_full_a: assert property (mul_p(7'h3C, e_tt)) else $error("tt product wrong");
  tt_shift14_a: assert property (mul_p(7'h3D, {{14{e_tt[63]}}, e_tt[63:14]}))
    else $error("tt shift14 wrong");
  tt_shift32_a: assert property (mul_p(7'h3E, {{32{e_tt[63]}}, e_tt[63:32]}))
    else $error("tt shift32 wrong");
  pack_ll_a: assert property (mul_p(7'h3F, {rs1_val[31:0], rs2_val[31:0]}))
    else $error("pack low low wrong");
  pack_lh_a: assert property (mul_p(7'h40, {rs1_val[31:0], rs2_val[63:32]}))
    else $error("pack low high wrong");
  pack_hh_a: assert property (mul_p(7'h41, {rs1_val[63:32], rs2_val[63:32]}))
    else $error("pack high high wrong");
  decode_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid && hit |=> wb_rd == $past(instr[11:7])) else $error("rd wrong");
  decode_miss_a: assert property (@(posedge clk) disable iff (sys_rst)
    (instr[6:0] != 7'h7B || instr[14:12] != 3'h0) |-> !hit)
    else $error("foreign hit");
  hh_hit_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_s(7'h41) |-> hit) else $error("high pack missed");
  no_exc_a: assert property (@(posedge clk) disable iff (sys_rst)
    issue_valid |=> !exc_raise) else $error("exception raised");

  // ----------------------------------------------------------------------------
  // Handshake and reset checks
  // ----------------------------------------------------------------------------
  sequence accept_s;
    issue_valid && hit;
  endsequence

  sequence idle_s;
    !(issue_valid && hit);
  endsequence

  sequence held_s;
    !wb_valid && $stable(wb_rd) && $stable(wb_data);
  endsequence

  // No disable here, so the clear itself is watched
  reset_clear_a: assert property (@(posedge clk)
    sys_rst |=> !wb_valid && wb_rd == 5'h00 && wb_data == 64'h0)
    else $error("reset left a result");

  result_land_a: assert property (@(posedge clk) disable iff (sys_rst)
    accept_s |=> wb_valid && wb_rd == $past(rd_idx) && wb_data == $past(res))
    else $error("accepted result not written");

  // A lone accept gives exactly one cycle of valid
  pulse_once_a: assert property (@(posedge clk) disable iff (sys_rst)
    accept_s ##1 idle_s |=> !wb_valid)
    else $error("result pulse too long");

  refused_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    idle_s |=> held_s)
    else $error("refused op changed the result");

  wb_origin_a: assert property (@(posedge clk) disable iff (sys_rst)
    wb_valid |-> $past(issue_valid && hit))
    else $error("result without an issue");

  // ----------------------------------------------------------------------------
  // Decode and operand routing checks
  // ----------------------------------------------------------------------------
  sequence member_s;
    instr[6:0] == `SWMP_OPCODE && instr[14:12] == `SWMP_SUBFUNC &&
    instr[31:25] >= `SWMP_F_BT_SH14 && instr[31:25] <= `SWMP_F_PK_HH;
  endsequence

  // Source indices leave early so the register file answers in the same cycle
  idx_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    rs1_idx == instr[19:15] && rs2_idx == instr[24:20])
    else $error("source index wrong");

  hit_space_a: assert property (@(posedge clk) disable iff (sys_rst)
    hit |-> member_s)
    else $error("hit outside the group");

  hit_full_a: assert property (@(posedge clk) disable iff (sys_rst)
    member_s |-> hit)
    else $error("group member missed");

  opnd_bt14_a: assert property (@(posedge clk) disable iff (sys_rst)
    op == swmp_pkg::SWMP_OP_BT_S14 |-> mul_a == rs1_val[31:0] && mul_b == rs2_val[63:32])
    else $error("bt14 operands wrong");

  opnd_bt32_a: assert property (@(posedge clk) disable iff (sys_rst)
    op == swmp_pkg::SWMP_OP_BT_S32 |-> mul_a == rs1_val[31:0] && mul_b == rs2_val[31:0])
    else $error("bt32 operands wrong");

  // The top-by-top forms share one operand pair
  opnd_tt_a: assert property (@(posedge clk) disable iff (sys_rst)
    op inside {swmp_pkg::SWMP_OP_TT, swmp_pkg::SWMP_OP_TT_S14, swmp_pkg::SWMP_OP_TT_S32} |->
      mul_a == rs1_val[63:32] && mul_b == rs2_val[63:32])
    else $error("tt operands wrong");

  // ----------------------------------------------------------------------------
  // Multiplier and shifter checks
  // ----------------------------------------------------------------------------
  mul_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    (mul_a == 32'h0 || mul_b == 32'h0) |-> prod == 64'h0)
    else $error("zero operand product");

  mul_sign_a: assert property (@(posedge clk) disable iff (sys_rst)
    (mul_a != 32'h0 && mul_b != 32'h0) |-> prod[63] == (mul_a[31] ^ mul_b[31]))
    else $error("product sign wrong");

  // Only the square of the most negative word reaches bit 62 alone
  mul_range_a: assert property (@(posedge clk) disable iff (sys_rst)
    prod[63] == prod[62] || prod == 64'h4000_0000_0000_0000)
    else $error("product out of range");

  // The shifted values keep a full sign fill above the product's reach
  sign_fill_a: assert property (@(posedge clk) disable iff (sys_rst)
    sh14[63:49] == {15{prod[63]}} && sh32[63:31] == {33{prod[63]}})
    else $error("shift sign fill wrong");

  shift_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
    sh14[49:0] == prod[63:14] && sh32[31:0] == prod[63:32])
    else $error("shift bits wrong");

  res_full_a: assert property (@(posedge clk) disable iff (sys_rst)
    op == swmp_pkg::SWMP_OP_TT |-> res == prod)
    else $error("full product not selected");

  res_sh14_a: assert property (@(posedge clk) disable iff (sys_rst)
    op inside {swmp_pkg::SWMP_OP_BT_S14, swmp_pkg::SWMP_OP_TT_S14} |-> res == sh14)
    else $error("shift14 not selected");

  res_sh32_a: assert property (@(posedge clk) disable iff (sys_rst)
    op inside {swmp_pkg::SWMP_OP_BT_S32, swmp_pkg::SWMP_OP_TT_S32} |-> res == sh32)
    else $error("shift32 not selected");

  // ----------------------------------------------------------------------------
  // Pack lane checks
  // ----------------------------------------------------------------------------
  // One pass per destination word; the upper word always comes from source one
  for (genvar ln = 0; ln < 2; ln++) begin : g_pack_chk
    logic [63:0] src_v;
    logic        take_hi;

    assign src_v   = (ln == 1) ? rs1_val : rs2_val;
    assign take_hi = (ln == 1) ? (op == swmp_pkg::SWMP_OP_PK_HH) :
                                 (op != swmp_pkg::SWMP_OP_PK_LL);

    pack_word_a: assert property (@(posedge clk) disable iff (sys_rst)
      op inside {swmp_pkg::SWMP_OP_PK_LL, swmp_pkg::SWMP_OP_PK_LH, swmp_pkg::SWMP_OP_PK_HH} |->
        res[32*ln +: 32] == (take_hi ? src_v[63:32] : src_v[31:0]))
      else $error("pack word wrong");
  end
endmodule

//--- sim/swmp_regfile.sv
// Register file model that feeds source operands to the datapath
`timescale 1ns/1ps
module swmp_regfile (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [63:0] wr_data,
  input  wire logic [4:0]  rd1_idx,
  input  wire logic [4:0]  rd2_idx,
  output logic [63:0]      rd1_data,
  output logic [63:0]      rd2_data
);
  logic [63:0] mem_q [32];
  initial for (int i = 0; i < 32; i++) mem_q[i] = 64'h0;
  always @(posedge clk) if (wr_en) mem_q[wr_idx] <= wr_data;
  // Register zero reads zero, whatever was written
  assign rd1_data = (rd1_idx == 5'h0) ? 64'h0 : mem_q[rd1_idx];
  assign rd2_data = (rd2_idx == 5'h0) ? 64'h0 : mem_q[rd2_idx];
endmodule

//--- sim/simd_word_multiply_pack_test.sv
// Self-checking bench of the word multiply and pack datapath
`timescale 1ns/1ps
`include "swmp_regs.svh"
module simd_word_multiply_pack_test;
  logic        clk, sys_rst, issue_valid, hit, wb_valid, exc_raise, wr_en;
  logic [31:0] instr;
  logic [63:0] rs1_val, rs2_val, wb_data, wr_data, s;
  logic [4:0]  rs1_idx, rs2_idx, wb_rd, wr_idx;
  logic [68:0] exp_q [$];
  logic [68:0] last_e, e;
  logic [63:0] sh [32];
  int          errors, samples_checked, cycles;

  swmp_top dut (.clk(clk), .sys_rst(sys_rst), .issue_valid(issue_valid), .instr(instr),
    .rs1_val(rs1_val), .rs2_val(rs2_val), .hit(hit), .rs1_idx(rs1_idx), .rs2_idx(rs2_idx),
    .wb_valid(wb_valid), .wb_rd(wb_rd), .wb_data(wb_data), .exc_raise(exc_raise));
  swmp_regfile rf (.clk(clk), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
    .rd1_idx(rs1_idx), .rd2_idx(rs2_idx), .rd1_data(rs1_val), .rd2_data(rs2_val));

  always #5 clk = ~clk;

  function logic [63:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 7);
    s = s ^ (s << 17);
    return s;
  endfunction

  function automatic logic [63:0] ref_of(logic [6:0] f, logic [63:0] a, logic [63:0] b);
    logic signed [63:0] p;
    logic signed [31:0] al, ah, bl, bh;
    al = a[31:0];
    ah = a[63:32];
    bl = b[31:0];
    bh = b[63:32];
    case (f)
      `SWMP_F_BT_SH14: p = (al * bh) >>> 14;
      `SWMP_F_BT_SH32: p = (al * bl) >>> 32;
      `SWMP_F_TT:      p = ah * bh;
      `SWMP_F_TT_SH14: p = (ah * bh) >>> 14;
      `SWMP_F_TT_SH32: p = (ah * bh) >>> 32;
      `SWMP_F_PK_LL:   p = {a[31:0], b[31:0]};
      `SWMP_F_PK_LH:   p = {a[31:0], b[63:32]};
      `SWMP_F_PK_HH:   p = {a[63:32], b[63:32]};
      default:         p = 64'h0;
    endcase
    return p;
  endfunction

  task automatic check(input string n, input logic [68:0] seen, input logic [68:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, ex, seen);
    end
  endtask

  task automatic load(input logic [4:0] i, input logic [63:0] v);
    @(posedge clk);
    #1 issue_valid = 1'b0;
    wr_en = 1'b1;
    wr_idx = i;
    wr_data = v;
    sh[i] = (i == 5'h0) ? 64'h0 : v;
    @(posedge clk);
    #1 wr_en = 1'b0;
  endtask

  task automatic issue(input logic v, input logic [6:0] f, input logic [2:0] sub,
                       input logic [6:0] opc, input logic [31:0] w);
    logic h;
    w[6:0] = opc;
    w[14:12] = sub;
    w[31:25] = f;
    h = opc == `SWMP_OPCODE && sub == `SWMP_SUBFUNC && f >= `SWMP_F_BT_SH14 && f <= `SWMP_F_PK_HH;
    @(posedge clk);
    #1 issue_valid = v;
    instr = w;
    #1 check("hit", hit, h);
    check("rs1_idx", rs1_idx, w[19:15]);
    check("rs2_idx", rs2_idx, w[24:20]);
    if (v && h) exp_q.push_back({w[11:7], ref_of(f, sh[w[19:15]], sh[w[24:20]])});
  endtask

  // ----------------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------------
  always @(negedge clk) begin
    if (!sys_rst) begin
      check("exc_raise", exc_raise, 1'b0);
      if (wb_valid === 1'b1 && exp_q.size() == 0) check("wb_valid", 1'b1, 1'b0);
      else if (wb_valid === 1'b1) begin
        e = exp_q.pop_front();
        last_e = e;
        check("wb_result", {wb_rd, wb_data}, e);
      end else check("wb_hold", {wb_rd, wb_data}, last_e);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk = 0; sys_rst = 1; issue_valid = 0; instr = 0; wr_en = 0; wr_idx = 0; wr_data = 0;
    s = 64'h9403; last_e = '0; errors = 0; samples_checked = 0; cycles = 0;
    foreach (sh[i]) sh[i] = 64'h0;
    repeat (6) @(posedge clk);
    #1 sys_rst = 0;
    load(5'h1, 64'h80000000_80000000);
    load(5'h2, 64'hFFFFFFFF_FFFFFFFF);
    load(5'h3, 64'h7FFFFFFF_80000001);
    for (int i = 4; i < 32; i++) load(5'(i), rnd());
    $display("test reset done");
    // Corner operands, then random ones, every code back to back
    for (int f = 'h3A; f <= 'h41; f++) begin
      issue(1'b1, 7'(f), 3'h0, `SWMP_OPCODE, {7'h0, 5'h3, 5'h1, 3'h0, 5'h4, 7'h0});
      issue(1'b1, 7'(f), 3'h0, `SWMP_OPCODE, 32'(rnd()));
    end
    load(5'h0, rnd());
    $display("test codes done");
    issue(1'b1, 7'h39, 3'h0, `SWMP_OPCODE, 32'(rnd()));
    issue(1'b1, 7'h42, 3'h0, `SWMP_OPCODE, 32'(rnd()));
    issue(1'b1, `SWMP_F_TT, 3'h1, `SWMP_OPCODE, 32'(rnd()));
    issue(1'b1, `SWMP_F_TT, 3'h0, 7'h5B, 32'(rnd()));
    issue(1'b0, `SWMP_F_TT, 3'h0, `SWMP_OPCODE, 32'(rnd()));
    load(5'h0, rnd());
    $display("test refused done");
    for (int i = 0; i < 200; i++) begin
      e = 69'(rnd());
      issue(e[8], 7'h38 + 7'(e[3:0] % 12), e[4] ? 3'h0 : e[7:5], `SWMP_OPCODE, 32'(rnd()));
    end
    load(5'h0, rnd());
    repeat (3) @(posedge clk);
    check("pending", exp_q.size(), 0);
    $display("test random done");
    print_verdict();
  end
endmodule
